// >>> rtqts_pkg.sv
// Constants and types shared by the rooftop quick-test sequencer
package rtqts_pkg;

  // Clock rate and the time figures the sequencer waits on
  localparam longint CLK_HZ      = 50_000_000;
  localparam longint INIT_WAIT_S = 120;       // 2 minutes
  localparam longint TEST_IDLE_S = 600;       // 10 minutes
  localparam longint DEBOUNCE_MS = 20;
  localparam longint INIT_WAIT_CYC = INIT_WAIT_S * CLK_HZ;
  localparam longint TEST_IDLE_CYC = TEST_IDLE_S * CLK_HZ;
  localparam longint DEBOUNCE_CYC  = (DEBOUNCE_MS * CLK_HZ) / 1000;

  // Counter widths
  localparam int TMR_W = 36;
  localparam int DEB_W = 20;

  // Display codes
  localparam logic [6:0] CODE_INIT = 7'h14;   // 20
  localparam logic [6:0] CODE_TEST = 7'h58;   // 88
  localparam logic [6:0] CODE_ONE  = 7'h01;
  localparam logic [6:0] CODE_TEN  = 7'h0A;

  // Step numbers
  localparam logic [5:0] STEP_FIRST     = 6'h01;
  localparam logic [5:0] STEP_UNIT_TYPE = 6'h01;
  localparam logic [5:0] STEP_COMP_CNT  = 6'h02;
  localparam logic [5:0] STEP_UNLOADER  = 6'h03;
  localparam logic [5:0] STEP_LINE_HZ   = 6'h04;
  localparam logic [5:0] STEP_DIP_FIRST = 6'h05;
  localparam logic [5:0] STEP_DIP_LAST  = 6'h08;
  localparam logic [5:0] STEP_ENTHALPY  = 6'h09;
  localparam logic [5:0] STEP_LOWP1     = 6'h0A;
  localparam logic [5:0] STEP_LOWP2     = 6'h0B;
  localparam logic [5:0] STEP_OIL1      = 6'h0C;
  localparam logic [5:0] STEP_OIL2      = 6'h0D;
  localparam logic [5:0] STEP_SENS_FIRST = 6'h0E;  // 14, start of second section
  localparam logic [5:0] STEP_RELAY_FIRST = 6'h18; // 24, start of third section
  localparam logic [5:0] STEP_LAST      = 6'h21;   // 33

  // Switch-bank bit positions (position N sits at bit N-1)
  localparam int DIP_RESET_BIT = 1;   // Positions 2..5 map to steps 5..8
  localparam int DIP_UNL_LO    = 5;   // Position 6
  localparam int DIP_UNL_HI    = 6;   // Position 7

  // Number of pin inputs passed through the synchroniser
  localparam int PIN_W = 13;

  typedef enum {
    ST_WAIT_OCC,
    ST_INIT,
    ST_READY,
    ST_STEP,
    ST_RESULT,
    ST_RUN
  } rtqts_state_e;

endpackage

// >>> rtqts_sequencer.sv
// Quick-test sequencer: button stepping, timeouts and two-digit display codes
`timescale 1ns/1ns

module rtqts_sequencer #(
  parameter longint INIT_WAIT = rtqts_pkg::INIT_WAIT_CYC,
  parameter longint TEST_IDLE = rtqts_pkg::TEST_IDLE_CYC,
  parameter longint DEB_TIME  = rtqts_pkg::DEBOUNCE_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       occContact,
  input  wire logic       dispButton,
  input  wire logic [7:0] dipSwitch,
  input  wire logic       enthalpy_contact,
  input  wire logic       lowPress1,
  input  wire logic       lowPress2,
  input  wire logic [6:0] hdrUnitType,
  input  wire logic [6:0] hdrCompCount,
  input  wire logic [6:0] hdrLineHz,
  input  wire logic [9:0] sensorOk,
  input  wire logic [9:0] relayOk,
  output logic [3:0]      dispHiFf,
  output logic [3:0]      dispLoFf,
  output logic            dispHiOnFf,
  output logic            dpHiFf,
  output logic            dpLoFf,
  output logic            alarmLedFf,
  output logic            testActiveFf,
  output logic            startUnitFf,
  output logic [5:0]      stepFf,
  output logic            checkStrobeFf
);
  import rtqts_pkg::*;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  localparam logic [TMR_W-1:0] INIT_LIM = TMR_W'(INIT_WAIT - 1);
  localparam logic [TMR_W-1:0] IDLE_LIM = TMR_W'(TEST_IDLE - 1);
  localparam logic [DEB_W-1:0] DEB_LIM  = DEB_W'(DEB_TIME - 1);

  rtqts_state_e           stateFf;
  rtqts_state_e           nxt_state;
  logic [PIN_W-1:0]       pinMetaFf;
  logic [PIN_W-1:0]       pinSyncFf;
  logic                   occ;
  logic                   button;
  logic [7:0]             dip;
  logic [DEB_W-1:0]       debCntFf;
  logic                   btnStableFf;
  logic                   pressPulseFf;
  logic [TMR_W-1:0]       timerFf;
  logic                   timeUp;
  logic [6:0]             nxt_code;
  logic                   nxt_isStep;
  logic                   nxt_hiOn;
  logic [6:0]             resultCode;

  // Two-stage synchroniser for every pin; only the second stage is read
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pinMetaFf <= '0;
      pinSyncFf <= '0;
    end
    else
    begin
      pinMetaFf <= {occContact, dispButton, dipSwitch, enthalpy_contact, lowPress1, lowPress2};
      pinSyncFf <= pinMetaFf;
    end
  end

  assign occ    = pinSyncFf[12];
  assign button = pinSyncFf[11];
  assign dip    = pinSyncFf[10:3];

  // Debounce: the level must hold for the full window before it is accepted
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      debCntFf    <= '0;
      btnStableFf <= 1'b0;
    end
    else if (button == btnStableFf)
      debCntFf <= '0;
    else if (debCntFf == DEB_LIM)
    begin
      debCntFf    <= '0;
      btnStableFf <= button;
    end
    else
      debCntFf <= debCntFf + 1'b1;
  end

  // One pulse per accepted press, on the accepted rising level only
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      pressPulseFf <= 1'b0;
    else
      pressPulseFf <= (debCntFf == DEB_LIM) && button && !btnStableFf;
  end

  // Inactivity timer, restarted by every press and every state change
  always_ff @(posedge sys_clk)
  begin
    if (rst || pressPulseFf || (nxt_state != stateFf))
      timerFf <= '0;
    else if (!timeUp)
      timerFf <= timerFf + 1'b1;
  end

  assign timeUp = (stateFf == ST_INIT) ? (timerFf >= INIT_LIM) : (timerFf >= IDLE_LIM);

  // Sequencing; a lost occupancy contact always drops back to waiting
  always_comb
  begin
    nxt_state = stateFf;
    case (stateFf)
      ST_WAIT_OCC: if (occ) nxt_state = ST_INIT;
      ST_INIT:
      begin
        if (pressPulseFf)
          nxt_state = ST_READY;
        else if (timeUp)
          nxt_state = ST_RUN;
      end
      ST_READY, ST_STEP:
      begin
        if (pressPulseFf)
          nxt_state = ST_STEP;
        else if (timeUp)
          nxt_state = ST_RUN;
        if (pressPulseFf && stateFf == ST_STEP)
          nxt_state = ST_RESULT;
      end
      ST_RESULT:
      begin
        if (pressPulseFf)
          nxt_state = (stepFf == STEP_LAST) ? ST_RUN : ST_STEP;
        else if (timeUp)
          nxt_state = ST_RUN;
      end
      ST_RUN: nxt_state = ST_RUN;
      default: nxt_state = ST_WAIT_OCC;
    endcase
    if (!occ)
      nxt_state = ST_WAIT_OCC;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      stateFf <= ST_WAIT_OCC;
    else
      stateFf <= nxt_state;
  end

  // Step counter only counts up; a press in ST_READY is the way back to the first step
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      stepFf <= '0;
    else if (pressPulseFf && stateFf == ST_READY)
      stepFf <= STEP_FIRST;
    else if (pressPulseFf && stateFf == ST_RESULT && stepFf != STEP_LAST)
      stepFf <= stepFf + 1'b1;
  end

  // Strobe asks the check logic to act on the step just confirmed
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      checkStrobeFf <= 1'b0;
    else
      checkStrobeFf <= pressPulseFf && (stateFf == ST_STEP);
  end

  // Result code per step; sections split at the named step bounds
  always_comb
  begin
    resultCode = '0;
    if (stepFf >= STEP_RELAY_FIRST)
      resultCode = {6'h00, relayOk[4'(stepFf - STEP_RELAY_FIRST)]};
    else if (stepFf >= STEP_SENS_FIRST)
      resultCode = {6'h00, sensorOk[4'(stepFf - STEP_SENS_FIRST)]};
    else if (stepFf >= STEP_DIP_FIRST && stepFf <= STEP_DIP_LAST)
      resultCode = {6'h00, dip[3'(stepFf - STEP_DIP_FIRST) + 3'(DIP_RESET_BIT)]};
    else
      case (stepFf)
        STEP_UNIT_TYPE: resultCode = hdrUnitType;
        STEP_COMP_CNT:  resultCode = hdrCompCount;
        STEP_UNLOADER:  resultCode = {5'h00, dip[DIP_UNL_HI], dip[DIP_UNL_LO]};
        STEP_LINE_HZ:   resultCode = hdrLineHz;
        STEP_ENTHALPY:  resultCode = {6'h00, pinSyncFf[2]};
        STEP_LOWP1:     resultCode = {6'h00, pinSyncFf[1]};
        STEP_LOWP2:     resultCode = {6'h00, pinSyncFf[0]};
        STEP_OIL1, STEP_OIL2: resultCode = CODE_ONE;
        default:        resultCode = '0;
      endcase
  end

  // Pick what the display shows for the current state
  always_comb
  begin
    nxt_code   = '0;
    nxt_isStep = 1'b0;
    nxt_hiOn   = 1'b0;
    case (stateFf)
      ST_INIT:   nxt_code = CODE_INIT;
      ST_READY:  nxt_code = CODE_TEST;
      ST_STEP:
      begin
        nxt_code   = {1'b0, stepFf};
        nxt_isStep = 1'b1;
      end
      ST_RESULT: nxt_code = resultCode;
      default:   nxt_code = '0;
    endcase
    // Unit type keeps its leading zero so it reads as a two-digit code
    nxt_hiOn = (nxt_code >= CODE_TEN)
               || (stateFf == ST_RESULT && stepFf == STEP_UNIT_TYPE);
  end

  // Display registers; the point follows each lit numeral of a step number
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dispHiFf   <= '0;
      dispLoFf   <= '0;
      dispHiOnFf <= 1'b0;
      dpHiFf     <= 1'b0;
      dpLoFf     <= 1'b0;
    end
    else
    begin
      dispHiFf   <= 4'(nxt_code / CODE_TEN);
      dispLoFf   <= 4'(nxt_code % CODE_TEN);
      dispHiOnFf <= nxt_hiOn;
      dpHiFf     <= nxt_isStep && nxt_hiOn;
      dpLoFf     <= nxt_isStep;
    end
  end

  // Mode outputs; start only ever asserted with occupancy closed
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      alarmLedFf   <= 1'b0;
      testActiveFf <= 1'b0;
      startUnitFf  <= 1'b0;
    end
    else
    begin
      alarmLedFf   <= (stateFf == ST_READY) || (stateFf == ST_STEP) || (stateFf == ST_RESULT);
      testActiveFf <= (stateFf == ST_READY) || (stateFf == ST_STEP) || (stateFf == ST_RESULT);
      startUnitFf  <= (stateFf == ST_RUN) && occ;
    end
  end

  sequence s_initPress;
    (stateFf == ST_INIT) && pressPulseFf && occ;
  endsequence

  sequence s_show88;
    (stateFf == ST_READY) ##1 (dispHiFf == 4'h8 && dispLoFf == 4'h8 && alarmLedFf);
  endsequence

  chk_init_code: assert property ((stateFf == ST_INIT) |=> (dispHiFf == 4'h2 && dispLoFf == 4'h0))
    else $error("init code not 20");
  chk_enter_test: assert property (s_initPress |=> s_show88)
    else $error("press during init did not show 88");
  chk_init_timeout: assert property ((stateFf == ST_INIT && timeUp && !pressPulseFf && occ) |=> (stateFf == ST_RUN))
    else $error("init timeout did not start unit");
  chk_step_point: assert property ((stateFf == ST_STEP) |=> (dpLoFf && dispLoFf == 4'(stepFf % 6'h0A)))
    else $error("step number shown wrongly");
  chk_result_nopoint: assert property ((stateFf == ST_RESULT) |=> (!dpLoFf && !dpHiFf))
    else $error("result shown with point");
  chk_idle_timeout: assert property ((stateFf == ST_STEP && timeUp && !pressPulseFf && occ) |=> (stateFf == ST_RUN))
    else $error("test idle timeout missed");
  chk_forward_only: assert property ((stateFf != ST_READY) |=> (stepFf >= $past(stepFf)))
    else $error("step went backward");
  chk_oil_one: assert property ((stateFf == ST_RESULT && (stepFf == STEP_OIL1 || stepFf == STEP_OIL2)) |=> (dispLoFf == 4'h1))
    else $error("oil step not 1");
  chk_occ_start: assert property (!occ |=> !startUnitFf)
    else $error("unit started while unoccupied");
  chk_press_once: assert property (pressPulseFf |=> !pressPulseFf [*2])
    else $error("press counted twice");

endmodule

// >>> rtqts_operator.sv
// Service-person model: presses the display button with clean or bouncy contact
`timescale 1ns/1ns
module rtqts_operator #(
  parameter int HOLD = 12
) (
  input  wire logic sys_clk,
  input  wire logic pressReq,
  input  wire logic bounceReq,
  output logic      dispButton,
  output logic      busy
);
  int hiCnt = 0;
  int loCnt = 0;

  // High phase then a released phase long enough for the release to settle
  always @(posedge sys_clk)
  begin
    if (hiCnt > 0)
    begin
      hiCnt <= hiCnt - 1;
      dispButton <= (hiCnt != 1);
      if (hiCnt == 1)
        loCnt <= HOLD;
    end
    else if (loCnt > 0)
      loCnt <= loCnt - 1;
    else if (pressReq)
    begin
      hiCnt <= HOLD;
      dispButton <= 1'h1;
    end
    else if (bounceReq)
    begin
      hiCnt <= 2;  // Contact chatter, far shorter than any sane debounce window
      dispButton <= 1'h1;
    end
    else
      dispButton <= 1'h0;  // Idle contact rests open; one process owns the pin
  end

  // Busy covers release too, so the next press is never glued to this one
  assign busy = (hiCnt > 0) || (loCnt > 0);
endmodule

// >>> test_rooftop_quick_test_sequencer.sv
// Self-checking bench for the rooftop quick-test sequencer
`timescale 1ns/1ns
module test_rooftop_quick_test_sequencer;
  import rtqts_pkg::*;
  localparam longint IW = 200;
  localparam longint TI = 400;
  logic        sys_clk = 1'h0;
  logic        rst = 1'h1;
  logic        occContact = 1'h0;
  logic        pressReq = 1'h0;
  logic        bounceReq = 1'h0;
  logic        dispButton;
  logic        opBusy;
  logic [7:0]  dipSwitch = 8'h56;
  logic        enthalpy_contact = 1'h1;
  logic        lowPress1 = 1'h1;
  logic        lowPress2 = 1'h0;
  logic [9:0]  sensorOk = 10'h2B5;
  logic [9:0]  relayOk = 10'h155;
  logic [3:0]  dispHiFf;
  logic [3:0]  dispLoFf;
  logic        dispHiOnFf;
  logic        dpHiFf;
  logic        dpLoFf;
  logic        alarmLedFf;
  logic        testActiveFf;
  logic        startUnitFf;
  logic [5:0]  stepFf;
  logic        checkStrobeFf;
  logic [10:0] disp;
  int          errCount = 0;
  int          testsRun = 0;
  int          strobeCnt = 0;

  // Header codes are factory-fixed, so they stay tied
  rtqts_sequencer #(.INIT_WAIT(IW), .TEST_IDLE(TI), .DEB_TIME(4)) dut (
    .sys_clk(sys_clk), .rst(rst), .occContact(occContact), .dispButton(dispButton),
    .dipSwitch(dipSwitch), .enthalpy_contact(enthalpy_contact), .lowPress1(lowPress1),
    .lowPress2(lowPress2), .hdrUnitType(7'h01), .hdrCompCount(7'h02), .hdrLineHz(7'h3C),
    .sensorOk(sensorOk), .relayOk(relayOk), .dispHiFf(dispHiFf), .dispLoFf(dispLoFf),
    .dispHiOnFf(dispHiOnFf), .dpHiFf(dpHiFf), .dpLoFf(dpLoFf), .alarmLedFf(alarmLedFf),
    .testActiveFf(testActiveFf), .startUnitFf(startUnitFf), .stepFf(stepFf),
    .checkStrobeFf(checkStrobeFf));

  rtqts_operator op (.sys_clk(sys_clk), .pressReq(pressReq), .bounceReq(bounceReq),
    .dispButton(dispButton), .busy(opBusy));

  // 50 MHz clock and a strobe tally
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (checkStrobeFf === 1'h1)
      strobeCnt <= strobeCnt + 1;
  assign disp = {dispHiOnFf, dispHiFf, dispLoFf, dpHiFf, dpLoFf};

  // Expected display: tens lit from 10 up or for a forced leading zero
  function automatic logic [10:0] dval(int v, bit pt, bit lead);
    logic on;
    on = (v >= 10) || lead;
    return {on, 4'(v / 10), 4'(v % 10), pt && on, pt};
  endfunction

  function automatic int expRes(int n);
    case (n)
      1: return 1;
      2: return 2;
      3: return {dipSwitch[6], dipSwitch[5]};
      4: return 60;
      9: return enthalpy_contact;
      10: return lowPress1;
      11: return lowPress2;
      12, 13: return 1;
      default: return n < 9 ? dipSwitch[n - 4] : n < 24 ? sensorOk[n - 14] : relayOk[n - 24];
    endcase
  endfunction

  task automatic printVerdict;
    if (errCount == 0 && testsRun > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Wide enough for the display word together with the step counter
  task automatic chkVal(logic [16:0] got, logic [16:0] exp, string what);
    testsRun++;
    if (got !== exp)
    begin
      errCount++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic hang(string what);
    errCount++;
    $display("BAD %0t wait ran out: %s", $time, what);
    printVerdict();
  endtask

  task automatic doReset;
    @(posedge sys_clk);
    rst <= 1'h1;
    occContact <= 1'h0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
  endtask

  // Press and wait for the operator to let go; sampled at the falling edge
  task automatic press(bit bounce);
    int k;
    @(posedge sys_clk);
    if (bounce)
      bounceReq <= 1'h1;
    else
      pressReq <= 1'h1;
    @(posedge sys_clk);
    bounceReq <= 1'h0;
    pressReq <= 1'h0;
    for (k = 0; k < 60; k++)
    begin
      @(negedge sys_clk);
      if (!opBusy)
        return;
    end
    hang("operator");
  endtask

  task automatic enterInit;
    int k;
    @(posedge sys_clk);
    occContact <= 1'h1;
    for (k = 0; k < 20; k++)
    begin
      @(negedge sys_clk);
      if (disp === dval(20, 0, 0))
        return;
    end
    hang("code 20");
  endtask

  task automatic waitStart(int lim, output int cnt);
    for (cnt = 0; cnt < lim; cnt++)
    begin
      @(negedge sys_clk);
      if (startUnitFf === 1'h1)
        return;
    end
    hang("unit start");
  endtask

  // Open contact blocks start; then init code and the two-minute fallback
  task automatic scOccupancy;
    int c;
    doReset();
    repeat (IW + 20) @(negedge sys_clk);
    chkVal(17'(startUnitFf), 17'h0, "start while unoccupied");
    enterInit();
    chkVal(17'(disp), 17'(dval(20, 0, 0)), "init code");
    waitStart(IW + 20, c);
    chkVal(17'(c >= IW - 5 && c <= IW + 5), 17'h1, "init wait length");
  endtask

  // Entry to test, a bounce that must not count, then a real press
  task automatic scEntry;
    doReset();
    enterInit();
    press(0);
    chkVal(17'(disp), 17'(dval(88, 0, 0)), "test code");
    chkVal(17'({alarmLedFf, testActiveFf}), 17'h3, "alarm on");
    press(1);
    chkVal({disp, stepFf}, {dval(88, 0, 0), 6'h00}, "bounce counted");
    press(0);
  endtask

  // Every step forward: number with points, then the result without
  task automatic scWalk;
    int n;
    int c;
    int s0;
    s0 = strobeCnt;
    for (n = 1; n <= 33; n++)
    begin
      if (n > 1)
        press(0);
      chkVal({disp, stepFf}, {dval(n, 1, 0), 6'(n)}, "step number");
      press(0);
      chkVal(17'(disp), 17'(dval(expRes(n), 0, n == 1)), "result");
    end
    chkVal(17'(strobeCnt - s0), 17'h21, "check count");
    press(0);
    waitStart(20, c);
    chkVal(17'(testActiveFf), 17'h0, "test left");
  endtask

  // Ten-minute idle fallback, then losing occupancy stops the unit
  task automatic scIdle;
    int c;
    doReset();
    enterInit();
    press(0);
    press(0);
    waitStart(TI + 20, c);
    chkVal(17'(c >= TI - 30 && c <= TI + 2), 17'h1, "idle length");
    @(posedge sys_clk);
    occContact <= 1'h0;
    repeat (6) @(negedge sys_clk);
    chkVal(17'(startUnitFf), 17'h0, "start after open");
  endtask

  initial
  begin
    repeat (2) @(posedge sys_clk);
    scOccupancy();
    scEntry();
    scWalk();
    scIdle();
    printVerdict();
  end
endmodule
